// ---- rtl/uef_top.sv ----
// Enhanced feature, divisor, flow threshold and trigger level registers of
// one channel, plus the shared FIFO ready status register.
// Assumes host strobes and FIFO status come from logic on clk; the
// clear-to-send pin is asynchronous.
`timescale 1ns/1ps

module uef_top (
   input wire logic clk, // Core clock, 100 MHz
   input wire logic reset, // Asynchronous reset, active high
   input wire logic ce, // Clock enable, freezes all state when low
   input wire logic chipSelA_n, // Channel A select, this channel
   input wire logic chipSelB_n, // Channel B select, FIFO ready only
   input wire logic [2:0] addr, // Register address
   input wire logic wrStrobe, // Write pulse
   input wire logic rdStrobe, // Read pulse
   input wire logic [7:0] wrData, // Write data
   output logic [7:0] rdData, // Read data, valid cycle after rdStrobe
   input wire logic clearToSendIn, // Clear-to-send pin, active low
   output logic requestToSendOut, // Request-to-send pin, active low
   output logic txHalt, // Transmitter must stop
   input wire logic [6:0] rxFifoLevel, // Receive FIFO fill in bytes
   input wire logic rxCharValid, // Assembled character pulse
   input wire logic [7:0] rxChar, // Assembled character
   output logic rxStore, // Store character in receive FIFO
   output logic specialCharDet, // Special character flag
   output logic [3:0] swFlowMode, // Software flow-control selection
   output logic [15:0] baudDivisor, // Baud divisor
   output logic sleepEnable, // Sleep mode requested
   output logic [5:0] rxTrigLevel, // Effective receive trigger, bytes
   output logic [5:0] txTrigLevel, // Effective transmit trigger, bytes
   input wire logic dmaTxRdyA, // Channel A transmit DMA ready
   input wire logic dmaTxRdyB, // Channel B transmit DMA ready
   input wire logic dmaRxRdyA, // Channel A receive DMA ready
   input wire logic dmaRxRdyB // Channel B receive DMA ready
);
   import uef_pkg::*;

   // ************************************************************
   // Registers
   // ************************************************************
   logic [7:0] featCtl_q;
   logic [7:0] divLow_q;
   logic [7:0] divHigh_q;
   logic [7:0] flowThresh_q;
   logic [7:0] trigLevels_q;
   logic [7:0] intEnable_q;
   logic [7:0] fifoCtl_q;
   logic [7:0] modemCtl_q;
   logic [7:0] lineCtl_q;
   logic [7:0] stopChar2_q;
   logic [7:0] rdData_d;
   uef_rts_state_t rtsState_q;
   logic ctsLevel;

   // ************************************************************
   // Decode
   // ************************************************************
   logic selA;
   logic wrA;
   logic featKey;
   logic divKey;
   logic extOpen;
   logic fifoRdyHit;
   logic [7:0] fifoReady;
   logic [6:0] haltBytes;
   logic [6:0] resumeBytes;

   assign selA = !chipSelA_n;
   assign wrA = ce && wrStrobe && selA;
   assign featKey = (lineCtl_q == LINE_KEY_FEATURE);
   // Bit 7 of the key opens the latches, so the feature key reaches them too
   assign divKey = lineCtl_q[7];
   assign extOpen = featCtl_q[FEAT_ENHANCED] && modemCtl_q[MODEM_EXT_REG_EN]
                    && !divKey;
   assign fifoRdyHit = (!chipSelA_n || !chipSelB_n)
                       && (addr == OFS_FIFO_READY)
                       && modemCtl_q[MODEM_FIFO_RDY_EN]
                       && !modemCtl_q[MODEM_LOOPBACK]
                       && !divKey;
   assign fifoReady = {2'b00, dmaRxRdyB, dmaRxRdyA,
                       2'b00, dmaTxRdyB, dmaTxRdyA};
   assign haltBytes = {1'b0, flowThresh_q[3:0], 2'b00};
   assign resumeBytes = {1'b0, flowThresh_q[7:4], 2'b00};

   uef_sync #(
      .RESET_LEVEL(1'b1)
   ) ctsSync (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .pinIn(clearToSendIn),
      .levelOut(ctsLevel)
   );

   // ************************************************************
   // Line control and key registers
   // ************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lineCtl_q <= RST_BYTE;
      end else if (wrA && addr == OFS_LINE_CTL) begin
         lineCtl_q <= wrData;
      end
   end

   // Feature register and second stop character behind the feature key
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         featCtl_q <= RST_BYTE;
         stopChar2_q <= RST_BYTE;
      end else if (wrA && featKey) begin
         if (addr == OFS_FEAT_CTL) begin
            featCtl_q <= wrData;
         end
         if (addr == OFS_STOP_CHAR2) begin
            stopChar2_q <= wrData;
         end
      end
   end

   // Divisor latches, frozen once sleep is on
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         divLow_q <= RST_DIVISOR[7:0];
         divHigh_q <= RST_DIVISOR[15:8];
      end else if (wrA && divKey && !intEnable_q[IE_SLEEP]) begin
         if (addr == OFS_DIV_LOW) begin
            divLow_q <= wrData;
         end
         if (addr == OFS_DIV_HIGH) begin
            divHigh_q <= wrData;
         end
      end
   end

   // ************************************************************
   // Protected base registers
   // ************************************************************
   // Masked bits (enable 7:4, FIFO control 5:4, modem 7:5) keep their value while the enhanced bit is low
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         intEnable_q <= RST_BYTE;
         fifoCtl_q <= RST_BYTE;
         modemCtl_q <= RST_BYTE;
      end else if (wrA && !divKey) begin
         if (addr == OFS_INT_ENABLE) begin
            intEnable_q <= featCtl_q[FEAT_ENHANCED] ? wrData :
               ((intEnable_q & IE_PROTECT_MASK)
                | (wrData & ~IE_PROTECT_MASK));
         end
         if (addr == OFS_FIFO_CTL) begin
            fifoCtl_q <= featCtl_q[FEAT_ENHANCED] ? wrData :
               ((fifoCtl_q & FIFO_CTL_PROTECT_MASK)
                | (wrData & ~FIFO_CTL_PROTECT_MASK));
         end
         if (addr == OFS_MODEM_CTL) begin
            modemCtl_q <= featCtl_q[FEAT_ENHANCED] ? wrData :
               ((modemCtl_q & MODEM_PROTECT_MASK)
                | (wrData & ~MODEM_PROTECT_MASK));
         end
      end else if (wrA && addr == OFS_MODEM_CTL) begin
         // The modem register stays reachable under either key
         modemCtl_q <= featCtl_q[FEAT_ENHANCED] ? wrData :
            ((modemCtl_q & MODEM_PROTECT_MASK)
             | (wrData & ~MODEM_PROTECT_MASK));
      end
   end

   // ************************************************************
   // Threshold and trigger registers
   // ************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flowThresh_q <= RST_BYTE;
         trigLevels_q <= RST_BYTE;
      end else if (wrA && extOpen) begin
         if (addr == OFS_FLOW_THRESH) begin
            flowThresh_q <= wrData;
         end
         if (addr == OFS_TRIG_LEVELS) begin
            trigLevels_q <= wrData;
         end
      end
   end

   // Effective trigger levels; a zero nibble hands control back
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rxTrigLevel <= RX_FIFO_CTL_TRIG[0];
         txTrigLevel <= TX_FIFO_CTL_TRIG[0];
      end else if (ce) begin
         rxTrigLevel <= (trigLevels_q[7:4] != 4'h0) ?
            {trigLevels_q[7:4], 2'b00} : RX_FIFO_CTL_TRIG[fifoCtl_q[7:6]];
         txTrigLevel <= (trigLevels_q[3:0] != 4'h0) ?
            {trigLevels_q[3:0], 2'b00} : TX_FIFO_CTL_TRIG[fifoCtl_q[5:4]];
      end
   end

   // ************************************************************
   // Hardware flow control
   // ************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         txHalt <= 1'b0;
      end else if (ce) begin
         txHalt <= featCtl_q[FEAT_AUTO_CTS] && ctsLevel;
      end
   end

   // Ordering of the two levels is left to software; with halt not above
   // resume the state simply follows the halt comparison first.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rtsState_q <= RTS_FLOW;
      end else if (ce) begin
         case (rtsState_q)
            RTS_FLOW: begin
               if (rxFifoLevel >= haltBytes) begin
                  rtsState_q <= RTS_HALT;
               end
            end
            RTS_HALT: begin
               if (rxFifoLevel <= resumeBytes) begin
                  rtsState_q <= RTS_FLOW;
               end
            end
            default: rtsState_q <= RTS_FLOW;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         requestToSendOut <= 1'b1;
      end else if (ce) begin
         if (featCtl_q[FEAT_AUTO_RTS]) begin
            requestToSendOut <= (rtsState_q == RTS_HALT);
         end else begin
            requestToSendOut <= !modemCtl_q[MODEM_RTS];
         end
      end
   end

   // ************************************************************
   // Special character detect
   // ************************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rxStore <= 1'b0;
      end else if (ce) begin
         rxStore <= rxCharValid;
      end
   end

   // Set wins over the clear by an identification read
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         specialCharDet <= 1'b0;
      end else if (ce) begin
         if (featCtl_q[FEAT_SPECIAL] && rxCharValid
             && rxChar == stopChar2_q) begin
            specialCharDet <= 1'b1;
         end else if (rdStrobe && selA && !divKey
                      && addr == OFS_INT_ID) begin
            specialCharDet <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Read path
   // ************************************************************
   always_comb begin
      rdData_d = RST_BYTE;
      if (fifoRdyHit) begin
         rdData_d = fifoReady;
      end else if (selA) begin
         case (addr)
            3'h0: rdData_d = divKey ? divLow_q : RST_BYTE;
            3'h1: rdData_d = divKey ? divHigh_q : intEnable_q;
            3'h2: rdData_d = featKey ? featCtl_q :
               (divKey ? RST_BYTE :
                {3'b000, specialCharDet, 3'b000, !specialCharDet});
            3'h3: rdData_d = lineCtl_q;
            3'h4: rdData_d = modemCtl_q;
            3'h6: rdData_d = extOpen ? flowThresh_q : RST_BYTE;
            3'h7: rdData_d = featKey ? stopChar2_q :
               (extOpen ? trigLevels_q : RST_BYTE);
            default: rdData_d = RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdData <= RST_BYTE;
      end else if (ce && rdStrobe) begin
         rdData <= rdData_d;
      end
   end

   // ************************************************************
   // Direct outputs
   // ************************************************************
   assign swFlowMode = featCtl_q[3:0];
   assign baudDivisor = {divHigh_q, divLow_q};
   assign sleepEnable = intEnable_q[IE_SLEEP];

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_cts_halt_follow:
      assert property (ce && featCtl_q[FEAT_AUTO_CTS] && ctsLevel
                       |=> txHalt)
      else $error("Auto CTS did not halt transmitter");

   a_rts_auto_high:
      assert property (ce && featCtl_q[FEAT_AUTO_RTS]
                       && rtsState_q == RTS_HALT |=> requestToSendOut)
      else $error("Auto RTS not high at halt level");

   a_rts_halt_entry:
      assert property (ce && rtsState_q == RTS_FLOW
                       && rxFifoLevel >= haltBytes
                       |=> rtsState_q == RTS_HALT)
      else $error("Halt level did not halt flow");

   a_special_flag_set:
      assert property (ce && featCtl_q[FEAT_SPECIAL] && rxCharValid
                       && rxChar == stopChar2_q
                       |=> specialCharDet && rxStore)
      else $error("Special character not flagged or stored");

   a_ie_upper_protect:
      assert property (wrA && !divKey && addr == OFS_INT_ENABLE
                       && !featCtl_q[FEAT_ENHANCED]
                       |=> intEnable_q[7:4] == $past(intEnable_q[7:4]))
      else $error("Protected enable bits changed");

   a_reset_features_off:
      assert property ($past(reset) |-> featCtl_q[7:5] == 3'b000)
      else $error("Features enabled after reset");

   a_divisor_sleep_lock:
      assert property (intEnable_q[IE_SLEEP] |=>
                       baudDivisor == $past(baudDivisor))
      else $error("Divisor changed during sleep");

   a_thresh_write_gate:
      assert property (wrA && addr == OFS_FLOW_THRESH && !extOpen
                       |=> flowThresh_q == $past(flowThresh_q))
      else $error("Threshold written while locked");

   a_rx_trigger_select:
      assert property (ce && trigLevels_q[7:4] != 4'h0
                       |=> rxTrigLevel == {$past(trigLevels_q[7:4]), 2'b00})
      else $error("Receive trigger override missing");

   a_fifo_ready_read:
      assert property (ce && rdStrobe && fifoRdyHit
                       |=> rdData == {2'b00, $past(dmaRxRdyB),
                                      $past(dmaRxRdyA), 2'b00,
                                      $past(dmaTxRdyB), $past(dmaTxRdyA)})
      else $error("FIFO ready read wrong");

   c_special_hit: cover property (specialCharDet);
   c_rts_halted: cover property (featCtl_q[FEAT_AUTO_RTS] && requestToSendOut);
   c_fifo_ready: cover property (rdStrobe && fifoRdyHit);
   c_tx_halted: cover property (txHalt);
endmodule

// ---- rtl/uef_pkg.sv ----
// Constants for the enhanced-feature and flow-control register block.
// Assumes an 8-bit host bus with a 3-bit address, one channel per chip select.
package uef_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [2:0] OFS_DIV_LOW = 3'h0;
   localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
   localparam logic [2:0] OFS_INT_ENABLE = 3'h1;
   localparam logic [2:0] OFS_FEAT_CTL = 3'h2;
   localparam logic [2:0] OFS_INT_ID = 3'h2;
   localparam logic [2:0] OFS_FIFO_CTL = 3'h2;
   localparam logic [2:0] OFS_LINE_CTL = 3'h3;
   localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
   localparam logic [2:0] OFS_FLOW_THRESH = 3'h6;
   localparam logic [2:0] OFS_TRIG_LEVELS = 3'h7;
   localparam logic [2:0] OFS_STOP_CHAR2 = 3'h7;
   localparam logic [2:0] OFS_FIFO_READY = 3'h7;

   // ************************************************************
   // Access keys held in the line control register
   // ************************************************************
   localparam logic [7:0] LINE_KEY_FEATURE = 8'hBF;
   localparam logic [7:0] LINE_KEY_DIVISOR = 8'h80;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int FEAT_AUTO_CTS = 7;
   localparam int FEAT_AUTO_RTS = 6;
   localparam int FEAT_SPECIAL = 5;
   localparam int FEAT_ENHANCED = 4;
   localparam int IE_SLEEP = 4;
   localparam int MODEM_RTS = 1;
   localparam int MODEM_FIFO_RDY_EN = 2;
   localparam int MODEM_LOOPBACK = 4;
   localparam int MODEM_EXT_REG_EN = 6;
   localparam logic [7:0] IE_PROTECT_MASK = 8'hF0;
   localparam logic [7:0] FIFO_CTL_PROTECT_MASK = 8'h30;
   localparam logic [7:0] MODEM_PROTECT_MASK = 8'hE0;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_DIVISOR = 16'h0000;

   // ************************************************************
   // Trigger levels chosen by the FIFO control register
   // ************************************************************
   localparam logic [5:0] RX_FIFO_CTL_TRIG [0:3] =
      '{6'h08, 6'h10, 6'h38, 6'h3C};
   localparam logic [5:0] TX_FIFO_CTL_TRIG [0:3] =
      '{6'h08, 6'h10, 6'h20, 6'h38};

   // ************************************************************
   // Auto request-to-send states
   // ************************************************************
   typedef enum logic [0:0] {
      RTS_FLOW = 1'b0,
      RTS_HALT = 1'b1
   } uef_rts_state_t;

endpackage

// ---- rtl/uef_sync.sv ----
// Three-stage synchroniser with agreement filter for one pin level.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module uef_sync #(
   parameter logic RESET_LEVEL = 1'b1 // Level held through reset
) (
   input wire logic clk, // Core clock
   input wire logic reset, // Asynchronous reset, active high
   input wire logic ce, // Clock enable
   input wire logic pinIn, // Asynchronous pin
   output logic levelOut // Filtered level
);
   logic stage1_q;
   logic stage2_q;
   logic stage3_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         stage1_q <= RESET_LEVEL;
         stage2_q <= RESET_LEVEL;
         stage3_q <= RESET_LEVEL;
         levelOut <= RESET_LEVEL;
      end else if (ce) begin
         stage1_q <= pinIn;
         stage2_q <= stage1_q;
         stage3_q <= stage2_q;
         // A change counts only once the last two stages agree
         if (stage2_q == stage3_q) begin
            levelOut <= stage3_q;
         end
      end
   end
endmodule

// ---- bench/uef_host_model.sv ----
// Host processor model driving the block's 8-bit register bus.
// Assumes the bench calls wr and rd; signals change at clk rising edges.
`timescale 1ns/1ps
module uef_host_model (
   input wire logic clk, // Core clock
   input wire logic [7:0] rdData, // Read data from the block
   output logic chipSelA_n, // Channel A select
   output logic chipSelB_n, // Channel B select
   output logic [2:0] addr, // Register address
   output logic wrStrobe, // Write pulse
   output logic rdStrobe, // Read pulse
   output logic [7:0] wrData // Write data
);
   initial begin
      {chipSelA_n, chipSelB_n, addr, wrStrobe, rdStrobe} = 7'h60;
      wrData = 8'h00;
   end
   // One-cycle write on channel A; data inverted after so none lingers
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      chipSelA_n <= 1'h0;
      addr <= a;
      wrData <= d;
      wrStrobe <= 1'h1;
      @(posedge clk);
      wrStrobe <= 1'h0;
      chipSelA_n <= 1'h1;
      wrData <= ~d;
   endtask
   // Read on either select; data is taken just after the next edge
   task automatic rd(input logic [2:0] a, input logic selB,
                     output logic [7:0] d);
      @(posedge clk);
      chipSelA_n <= selB;
      chipSelB_n <= ~selB;
      addr <= a;
      rdStrobe <= 1'h1;
      @(posedge clk);
      rdStrobe <= 1'h0;
      {chipSelA_n, chipSelB_n} <= 2'h3;
      #1 d = rdData;
   endtask
endmodule

// ---- bench/test_uart_enhanced_flow_config.sv ----
// Self-checking bench for the enhanced feature and flow register block.
// Assumes uef_top and the host model; bus traffic goes through the model.
`timescale 1ns/1ps
module test_uart_enhanced_flow_config;
   import uef_pkg::*;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic ctsIn = 1'h0;
   logic rxValid = 1'h0;
   logic [6:0] lvl = 7'h00;
   logic [7:0] rxChr = 8'h00;
   logic [3:0] dma = 4'h0;
   logic csA_n, csB_n, wrS, rdS, rts, halt, store, spDet, sleepEn;
   logic [2:0] addr;
   logic [7:0] wrD, rdD, v;
   logic [3:0] swMode;
   logic [15:0] div;
   logic [5:0] rxTrig, txTrig;
   int failCount = 0;
   int checksDone = 0;
   always #5 clk = ~clk;
   uef_host_model host (.clk(clk), .rdData(rdD), .chipSelA_n(csA_n),
      .chipSelB_n(csB_n), .addr(addr), .wrStrobe(wrS), .rdStrobe(rdS),
      .wrData(wrD));
   uef_top DUT (.clk(clk), .reset(reset), .ce(1'h1), .chipSelA_n(csA_n),
      .chipSelB_n(csB_n), .addr(addr), .wrStrobe(wrS), .rdStrobe(rdS),
      .wrData(wrD), .rdData(rdD), .clearToSendIn(ctsIn),
      .requestToSendOut(rts), .txHalt(halt), .rxFifoLevel(lvl),
      .rxCharValid(rxValid), .rxChar(rxChr), .rxStore(store),
      .specialCharDet(spDet), .swFlowMode(swMode), .baudDivisor(div),
      .sleepEnable(sleepEn), .rxTrigLevel(rxTrig), .txTrigLevel(txTrig),
      .dmaTxRdyA(dma[0]), .dmaTxRdyB(dma[1]), .dmaRxRdyA(dma[2]),
      .dmaRxRdyB(dma[3]));
   // ************
   // Helpers
   // ************
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checksDone++;
      if (g !== e) begin
         failCount++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task key(input logic [7:0] k);
      host.wr(OFS_LINE_CTL, k);
   endtask
   // Line control is cleared to 00 after the access
   task feat(input logic [7:0] f);
      key(LINE_KEY_FEATURE);
      host.wr(OFS_FEAT_CTL, f);
      key(8'h00);
   endtask
   task waitHalt(input logic e);
      for (int i = 0; i < 12 && halt !== e; i++) cyc(1);
      chk("txHalt", {15'h0000, e}, {15'h0000, halt});
   endtask
   task rxSend(input logic [7:0] c);
      @(posedge clk);
      rxChr <= c;
      rxValid <= 1'h1;
      @(posedge clk);
      rxValid <= 1'h0;
      #1 chk("rxStore", 16'h0001, {15'h0000, store});
   endtask
   // ************
   // Scenarios
   // ************
   task testReset;
      key(LINE_KEY_FEATURE);
      host.rd(OFS_FEAT_CTL, 1'h0, v);
      chk("feature", 16'h0000, {8'h00, v});
      chk("rts", 16'h0001, {15'h0000, rts});
      chk("div", 16'h0000, div);
   endtask
   task testProtect;
      key(8'h00);
      host.wr(OFS_INT_ENABLE, 8'h10);
      host.wr(OFS_MODEM_CTL, 8'h40);
      host.wr(OFS_TRIG_LEVELS, 8'h53);
      cyc(2);
      chk("sleep", 16'h0000, {15'h0000, sleepEn});
      chk("rxTrig", {10'h000, RX_FIFO_CTL_TRIG[0]}, {10'h000, rxTrig});
   endtask
   task testDivisor;
      key(LINE_KEY_DIVISOR);
      host.wr(OFS_DIV_LOW, 8'h34);
      host.wr(OFS_DIV_HIGH, 8'h12);
      cyc(1);
      chk("div", 16'h1234, div);
      feat(8'h1A);
      chk("swMode", 16'h000A, {12'h000, swMode});
      host.wr(OFS_INT_ENABLE, 8'h10);
      key(LINE_KEY_DIVISOR);
      host.wr(OFS_DIV_LOW, 8'h99);
      cyc(1);
      chk("divSleep", 16'h1234, div);
      key(8'h00);
      host.wr(OFS_INT_ENABLE, 8'h00);
   endtask
   task testTrig;
      host.wr(OFS_TRIG_LEVELS, 8'h53);
      cyc(2);
      chk("rxTrig", 16'h0008, {10'h000, rxTrig});
      host.wr(OFS_MODEM_CTL, 8'h42);
      host.wr(OFS_TRIG_LEVELS, 8'h53);
      cyc(2);
      chk("rxTrig", 16'h0014, {10'h000, rxTrig});
      chk("txTrig", 16'h000C, {10'h000, txTrig});
      host.wr(OFS_TRIG_LEVELS, 8'h30);
      cyc(2);
      chk("rxTrig", 16'h000C, {10'h000, rxTrig});
      chk("txTrig", {10'h000, TX_FIFO_CTL_TRIG[0]}, {10'h000, txTrig});
      host.wr(OFS_FLOW_THRESH, 8'h28);
   endtask
   task testRts;
      logic [6:0] lv[4];
      logic ex[4];
      lv = '{7'h1F, 7'h20, 7'h09, 7'h08};
      ex = '{1'h0, 1'h1, 1'h1, 1'h0};
      feat(8'h50);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) lvl <= lv[i];
         cyc(3);
         chk("rts", {15'h0000, ex[i]}, {15'h0000, rts});
      end
   endtask
   task testCts;
      @(posedge clk) ctsIn <= 1'h1;
      cyc(8);
      chk("haltOff", 16'h0000, {15'h0000, halt});
      feat(8'h90);
      waitHalt(1'h1);
      @(posedge clk) ctsIn <= 1'h0;
      waitHalt(1'h0);
   endtask
   task testSpecial;
      key(LINE_KEY_FEATURE);
      host.wr(OFS_STOP_CHAR2, 8'h13);
      host.wr(OFS_FEAT_CTL, 8'h30);
      key(8'h00);
      rxSend(8'h11);
      cyc(1);
      chk("noMatch", 16'h0000, {15'h0000, spDet});
      rxSend(8'h13);
      cyc(1);
      chk("match", 16'h0001, {15'h0000, spDet});
      host.rd(OFS_INT_ID, 1'h0, v);
      chk("ident", 16'h0010, {8'h00, v});
      host.rd(OFS_INT_ID, 1'h0, v);
      chk("ident", 16'h0001, {8'h00, v});
   endtask
   task testFifoRdy;
      host.wr(OFS_MODEM_CTL, 8'h04);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk) dma <= i ? 4'h6 : 4'h9;
         host.rd(OFS_FIFO_READY, ~i[0], v);
         chk("fifoRdy", {8'h00, 2'h0, dma[3:2], 2'h0, dma[1:0]},
             {8'h00, v});
      end
   endtask
   task endOfTest;
      $display("checks %0d mismatches %0d", checksDone, failCount);
      if (failCount == 0 && checksDone > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      #200000;
      failCount++;
      endOfTest();
   end
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'h0;
      testReset();
      testProtect();
      testDivisor();
      testTrig();
      testRts();
      testCts();
      testSpecial();
      testFifoRdy();
      endOfTest();
   end
endmodule
